// >>> oibc_pkg.sv
// package for the optional input block control sequencer
// assumes one clock, async active-low reset, block interpreter upstream
`default_nettype none
package oibc_pkg;
  localparam int NUM_OPT = 7;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_MAX = 3'h6;
  localparam int HOST_OPT = 5;
  localparam int SEL_GEN1 = 5;
  localparam int SEL_GEN2 = 6;

  typedef enum logic [2:0] {
    OIBC_CMD_OTHER,
    OIBC_CMD_OPTIONAL_END,
    OIBC_CMD_OPTIONAL_SKIP,
    OIBC_CMD_OPTIONAL_PAUSE,
    OIBC_CMD_SUBPROGRAM_END,
    OIBC_CMD_PROGRAM_END,
    OIBC_CMD_DWELL_TIMER,
    OIBC_CMD_AXIS_MOVE
  } oibc_cmd_e;

  // one decoded block as the interpreter hands it over
  typedef struct packed {
    oibc_cmd_e cmd;
    logic [SEL_W-1:0] sel;
  } oibc_blk_s;

  typedef enum logic [1:0] {
    OIBC_DEC_RUN,
    OIBC_DEC_SKIP,
    OIBC_DEC_PAUSE
  } oibc_dec_e;
endpackage
`default_nettype wire

// >>> oibc_top.sv
// optional end / skip / pause sequencer of a motion program interpreter
// assumes blocks arrive by valid/ready, one handshake per block, and that
// the axis unit reports when a stop request has been honoured; a dwell cancel is not waited on
`default_nettype none
module oibc_top (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic [oibc_pkg::HOST_OPT-1:0] HOST_OPT_I,
  input wire logic GEN_IN1_I,
  input wire logic GEN_IN2_I,
  input wire logic PASS_MODE_I,
  input wire logic BLK_VALID_I,
  output logic BLK_READY_O,
  input wire oibc_pkg::oibc_blk_s BLK_I,
  output logic EXEC_VALID_O,
  output oibc_pkg::oibc_blk_s EXEC_BLK_O,
  output logic SKIP_O,
  output logic PAUSE_O,
  output logic SEL_ERR_O,
  input wire logic EXEC_DONE_I,
  output logic DECEL_REQ_O,
  output logic DWELL_CANCEL_O,
  input wire logic STOPPED_I,
  input wire logic RESUME_I
);
  import oibc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // input synchroniser; stage one is only read by stage two
  logic [NUM_OPT-1:0] opt_meta;
  logic [NUM_OPT-1:0] opt_sync;
  logic [NUM_OPT-1:0] opt_raw;

  assign opt_raw = {GEN_IN2_I, GEN_IN1_I, HOST_OPT_I};

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      opt_meta <= '0;
      opt_sync <= '0;
    end
    else
    begin
      opt_meta <= opt_raw;
      opt_sync <= opt_meta;
    end
  end

  // edges since reset; a two-deep past reaches back into reset before this
  logic [1:0] rst_age;

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      rst_age <= '0;
    end
    else if (rst_age != 2'h3)
    begin
      rst_age <= rst_age + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_EXEC,
    ST_STOP,
    ST_PAUSED
  } st_e;

  st_e state;
  oibc_cmd_e pend_cmd;
  logic [SEL_W-1:0] pend_sel;
  logic watch;
  oibc_cmd_e run_cmd;

  logic take;
  logic sel_ok;
  logic pend_in;
  logic last_blk;

  assign sel_ok = (BLK_I.sel <= SEL_MAX);
  assign pend_in = opt_sync[pend_sel];
  assign last_blk = (BLK_I.cmd == OIBC_CMD_SUBPROGRAM_END) ||
                    (BLK_I.cmd == OIBC_CMD_PROGRAM_END);
  // a new block only enters while idle or armed; exec holds it off
  assign BLK_READY_O = (state == ST_IDLE) || (state == ST_ARMED);
  assign take = BLK_VALID_I && BLK_READY_O;

  // the optional input is sampled at the block handshake, and for an optional
  // end again while its block runs; PASS_MODE_I is not used by the sequencer
  logic blk_is_opt;
  assign blk_is_opt = (BLK_I.cmd == OIBC_CMD_OPTIONAL_END) ||
                      (BLK_I.cmd == OIBC_CMD_OPTIONAL_SKIP) ||
                      (BLK_I.cmd == OIBC_CMD_OPTIONAL_PAUSE);

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state <= ST_IDLE;
      pend_cmd <= OIBC_CMD_OTHER;
      pend_sel <= '0;
      watch <= 1'b0;
      run_cmd <= OIBC_CMD_OTHER;
      EXEC_VALID_O <= 1'b0;
      EXEC_BLK_O <= '0;
      SKIP_O <= 1'b0;
      PAUSE_O <= 1'b0;
      SEL_ERR_O <= 1'b0;
      DECEL_REQ_O <= 1'b0;
      DWELL_CANCEL_O <= 1'b0;
    end
    else
    begin
      EXEC_VALID_O <= 1'b0;
      SKIP_O <= 1'b0;
      SEL_ERR_O <= 1'b0;
      unique case (state)
        ST_IDLE, ST_ARMED:
        begin
          if (take && blk_is_opt)
          begin
            if (sel_ok)
            begin
              pend_cmd <= BLK_I.cmd;
              pend_sel <= BLK_I.sel;
              state <= ST_ARMED;
            end
            else
            begin
              SEL_ERR_O <= 1'b1;
              state <= ST_IDLE;
            end
          end
          else if (take && state == ST_ARMED && last_blk)
          begin
            // end/skip have no effect on a closing block
            EXEC_VALID_O <= 1'b1;
            EXEC_BLK_O <= BLK_I;
            run_cmd <= BLK_I.cmd;
            watch <= 1'b0;
            state <= EXEC_DONE_I ? ST_IDLE : ST_EXEC;
          end
          else if (take && state == ST_ARMED && pend_in &&
                   pend_cmd != OIBC_CMD_OPTIONAL_PAUSE)
          begin
            // input already on: end behaves as skip
            SKIP_O <= 1'b1;
            state <= ST_IDLE;
          end
          else if (take && state == ST_ARMED && pend_in)
          begin
            PAUSE_O <= 1'b1;
            EXEC_BLK_O <= BLK_I;
            run_cmd <= BLK_I.cmd;
            state <= ST_PAUSED;
          end
          else if (take)
          begin
            EXEC_VALID_O <= 1'b1;
            EXEC_BLK_O <= BLK_I;
            run_cmd <= BLK_I.cmd;
            // only optional end keeps watching; a skip is decided already
            watch <= (state == ST_ARMED) &&
                     (pend_cmd == OIBC_CMD_OPTIONAL_END);
            state <= ST_EXEC;
          end
        end
        ST_EXEC:
        begin
          if (EXEC_DONE_I)
          begin
            watch <= 1'b0;
            state <= ST_IDLE;
          end
          else if (watch && pend_in)
          begin
            watch <= 1'b0;
            if (run_cmd == OIBC_CMD_DWELL_TIMER)
            begin
              DWELL_CANCEL_O <= 1'b1;
              state <= ST_IDLE;
            end
            else
            begin
              // moves must ramp down; cutting them would jerk the axes
              DECEL_REQ_O <= 1'b1;
              state <= ST_STOP;
            end
          end
        end
        ST_STOP:
        begin
          if (STOPPED_I || EXEC_DONE_I)
          begin
            DECEL_REQ_O <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_PAUSED:
        begin
          if (RESUME_I)
          begin
            PAUSE_O <= 1'b0;
            EXEC_VALID_O <= 1'b1;
            state <= ST_EXEC;
          end
        end
      endcase
      if (state != ST_EXEC)
      begin
        DWELL_CANCEL_O <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // synchroniser, arming and selector
  sync_delay_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    rst_age[1] |-> (opt_sync == $past(opt_raw, 2))) else
    $error("input sync not two stages");
  sel_range_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && blk_is_opt && BLK_I.sel > SEL_MAX) |=> SEL_ERR_O) else
    $error("bad selector not flagged");
  sel_disarm_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && blk_is_opt && !sel_ok) |=> (state == ST_IDLE && !EXEC_VALID_O)) else
    $error("bad selector left command armed");
  opt_quiet_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && blk_is_opt && sel_ok) |=>
    (state == ST_ARMED && !EXEC_VALID_O && !SKIP_O && !SEL_ERR_O)) else
    $error("optional command ran as a block");
  // skip and closing blocks
  skip_on_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && state == ST_ARMED && pend_in && !last_blk && !blk_is_opt &&
     pend_cmd != OIBC_CMD_OPTIONAL_PAUSE) |=> (SKIP_O && !EXEC_VALID_O)) else
    $error("skip not taken");
  skip_idle_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    SKIP_O |-> (state == ST_IDLE && !EXEC_VALID_O)) else
    $error("skipped block still running");
  skip_off_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && state == ST_ARMED && !pend_in && !blk_is_opt) |=> EXEC_VALID_O) else
    $error("block lost without input");
  last_keep_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && state == ST_ARMED && last_blk) |=> (EXEC_VALID_O && !SKIP_O)) else
    $error("closing block skipped");
  last_nowatch_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && state == ST_ARMED && last_blk) |=> !watch) else
    $error("closing block watched");
  // end watch and interruption
  end_watch_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && state == ST_ARMED && !pend_in && !last_blk && !blk_is_opt &&
     pend_cmd == OIBC_CMD_OPTIONAL_END) |=> (watch && EXEC_VALID_O)) else
    $error("end not watching its block");
  skip_nowatch_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (state == ST_EXEC && pend_cmd == OIBC_CMD_OPTIONAL_SKIP) |-> !watch) else
    $error("skip watching running block");
  exec_hold_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (state == ST_EXEC && !watch && !EXEC_DONE_I) |=> (state == ST_EXEC)) else
    $error("unwatched block cut short");
  exec_blk_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && !blk_is_opt) |=> (SKIP_O || EXEC_BLK_O == $past(BLK_I))) else
    $error("wrong block handed on");
  end_interrupt_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (state == ST_EXEC && watch && pend_in && !EXEC_DONE_I &&
     run_cmd != OIBC_CMD_DWELL_TIMER) |=> (DECEL_REQ_O && state == ST_STOP)) else
    $error("end did not interrupt");
  decel_hold_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (state == ST_STOP && !STOPPED_I && !EXEC_DONE_I) |=> DECEL_REQ_O) else
    $error("decel dropped early");
  decel_clear_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (state == ST_STOP && (STOPPED_I || EXEC_DONE_I)) |=>
    (!DECEL_REQ_O && state == ST_IDLE)) else
    $error("decel not released");
  dwell_cut_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (state == ST_EXEC && watch && pend_in && !EXEC_DONE_I &&
     run_cmd == OIBC_CMD_DWELL_TIMER) |=> (DWELL_CANCEL_O && state == ST_IDLE)) else
    $error("dwell not cancelled");
  dwell_pulse_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    DWELL_CANCEL_O |=> !DWELL_CANCEL_O) else
    $error("dwell cancel longer than a cycle");
  done_wins_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (state == ST_EXEC && EXEC_DONE_I) |=>
    (state == ST_IDLE && !DECEL_REQ_O && !DWELL_CANCEL_O)) else
    $error("finished block still interrupted");
  // pause
  pause_on_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (take && state == ST_ARMED && pend_in && !last_blk && !blk_is_opt &&
     pend_cmd == OIBC_CMD_OPTIONAL_PAUSE) |=> (PAUSE_O && !EXEC_VALID_O && !SKIP_O)) else
    $error("pause not taken");
  pause_hold_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (state == ST_PAUSED && !RESUME_I) |=>
    (PAUSE_O && state == ST_PAUSED && !EXEC_VALID_O)) else
    $error("pause left without resume");
  resume_run_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (state == ST_PAUSED && RESUME_I) |=>
    (EXEC_VALID_O && !PAUSE_O && state == ST_EXEC)) else
    $error("paused block not started on resume");
  // main scenarios, for coverage only
  cov_skip_c: cover property (@(posedge CLK_I) disable iff (!ARST_N_I) SKIP_O);
  cov_decel_c: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    $rose(DECEL_REQ_O));
  cov_dwell_c: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    DWELL_CANCEL_O);
  cov_pause_c: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    $rose(PAUSE_O));
  cov_resume_c: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    $fell(PAUSE_O));
endmodule
`default_nettype wire

// >>> oibc_opt_model.sv
// host data area and general inputs feeding the sequencer
// assumes the bench sets the wanted input levels between blocks
`default_nettype none
module oibc_opt_model (
  input wire logic [6:0] want_i,
  output wire logic [4:0] host_o,
  output wire logic gen1_o,
  output wire logic gen2_o
);
  // levels held steady before the block is offered
  assign host_o = want_i[4:0];
  assign gen1_o = want_i[5];
  assign gen2_o = want_i[6];
endmodule
`default_nettype wire

// >>> optional_input_block_control_bench.sv
// self-checking bench of the optional end/skip sequencer
// assumes oibc_pkg, oibc_top and oibc_opt_model are compiled first
`default_nettype none
module optional_input_block_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import oibc_pkg::*;
  logic clk = 0, arst_n = 0, pass = 0, valid = 0, done_i = 0, stop_i = 0, resume = 0;
  logic [6:0] want = '0;
  logic [4:0] host;
  logic gen1, gen2, ready, xv, skip, pause, serr, decel, dcan, decel_d, pause_d;
  oibc_blk_s blk = '0;
  oibc_blk_s xb;
  logic [2:0] exp_q[$];
  logic [2:0] seen;
  logic [2:0] last_cmd = '0;
  logic [31:0] seed = 32'h3A;
  int n_mismatch = 0, comparisons = 0;
  ////////////////////////////////////////////////////////////////////////
  oibc_opt_model i_oibc_opt_model (.want_i(want), .host_o(host), .gen1_o(gen1),
    .gen2_o(gen2));
  oibc_top i_oibc_top (.CLK_I(clk), .ARST_N_I(arst_n), .HOST_OPT_I(host),
    .GEN_IN1_I(gen1), .GEN_IN2_I(gen2), .PASS_MODE_I(pass), .BLK_VALID_I(valid),
    .BLK_READY_O(ready), .BLK_I(blk), .EXEC_VALID_O(xv), .EXEC_BLK_O(xb),
    .SKIP_O(skip), .PAUSE_O(pause), .SEL_ERR_O(serr), .EXEC_DONE_I(done_i),
    .DECEL_REQ_O(decel), .DWELL_CANCEL_O(dcan), .STOPPED_I(stop_i),
    .RESUME_I(resume));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [2:0] got, input logic [2:0] expv, input string what);
    comparisons++;
    if (got !== expv)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, expv, got);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // input settles over the two-flop sync before a block is offered
  task automatic opt(input logic [6:0] w);
    @(posedge clk);
    want <= w;
    pass <= 1'(rnd());
    repeat (3) @(posedge clk);
  endtask
  task automatic put(input oibc_cmd_e c, input logic [2:0] s);
    @(posedge clk);
    valid <= 1'b1;
    blk <= '{cmd: c, sel: s};
    do @(posedge clk); while (ready !== 1'b1);
    valid <= 1'b0;
    last_cmd <= c;
  endtask
  task automatic fin();
    repeat (3) @(posedge clk);
    done_i <= 1'b1;
    @(posedge clk);
    done_i <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // code per event: 0 run, 1 skip, 2 bad selector, 3 decel, 4 dwell cut, 5 pause
  always @(posedge clk)
  begin
    decel_d <= decel;
    pause_d <= pause;
    if (xv | skip | serr | dcan | (decel & ~decel_d) | (pause & ~pause_d))
    begin
      seen = xv ? 3'h0 : skip ? 3'h1 : serr ? 3'h2 : dcan ? 3'h4 :
        (decel & ~decel_d) ? 3'h3 : 3'h5;
      if (xv)
        check(xb.cmd, last_cmd, "exec block");
      if (exp_q.size() == 0)
        check(seen, 3'h7, "event");
      else
        check(seen, exp_q.pop_front(), "event");
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int s = 0; s < 7; s++)
    begin
      opt(7'h1 << s);
      put(OIBC_CMD_OPTIONAL_SKIP, 3'(s));
      exp_q.push_back(3'h1);
      put(OIBC_CMD_AXIS_MOVE, 3'h0);
      opt(7'(rnd()) & ~(7'h1 << s));
      put(OIBC_CMD_OPTIONAL_SKIP, 3'(s));
      exp_q.push_back(3'h0);
      put(OIBC_CMD_AXIS_MOVE, 3'h0);
      fin();
    end
    opt(7'h08);
    put(OIBC_CMD_OPTIONAL_SKIP, 3'h3);
    exp_q.push_back(3'h0);
    put(OIBC_CMD_PROGRAM_END, 3'h0);
    fin();
    put(OIBC_CMD_OPTIONAL_END, 3'h3);
    exp_q.push_back(3'h0);
    put(OIBC_CMD_SUBPROGRAM_END, 3'h0);
    fin();
    put(OIBC_CMD_OPTIONAL_END, 3'h3);
    exp_q.push_back(3'h1);
    put(OIBC_CMD_AXIS_MOVE, 3'h0);
    opt(7'h00);
    put(OIBC_CMD_OPTIONAL_END, 3'h3);
    exp_q.push_back(3'h0);
    put(OIBC_CMD_AXIS_MOVE, 3'h0);
    exp_q.push_back(3'h3);
    opt(7'h08);
    for (int i = 0; i < 20 && decel !== 1'b1; i++) @(posedge clk);
    stop_i <= 1'b1;
    @(posedge clk);
    stop_i <= 1'b0;
    @(posedge clk);
    check({2'b00, decel}, 3'h0, "decel release");
    opt(7'h00);
    put(OIBC_CMD_OPTIONAL_END, 3'h3);
    exp_q.push_back(3'h0);
    put(OIBC_CMD_DWELL_TIMER, 3'h0);
    exp_q.push_back(3'h4);
    opt(7'h08);
    opt(7'h00);
    put(OIBC_CMD_OPTIONAL_SKIP, 3'h3);
    exp_q.push_back(3'h0);
    put(OIBC_CMD_AXIS_MOVE, 3'h0);
    opt(7'h08);
    fin();
    put(OIBC_CMD_OPTIONAL_PAUSE, 3'h3);
    exp_q.push_back(3'h5);
    put(OIBC_CMD_AXIS_MOVE, 3'h0);
    repeat (4) @(posedge clk);
    exp_q.push_back(3'h0);
    resume <= 1'b1;
    @(posedge clk);
    resume <= 1'b0;
    fin();
    opt(7'h00);
    put(OIBC_CMD_OPTIONAL_PAUSE, 3'h3);
    exp_q.push_back(3'h0);
    put(OIBC_CMD_AXIS_MOVE, 3'h0);
    fin();
    exp_q.push_back(3'h2);
    put(OIBC_CMD_OPTIONAL_SKIP, 3'h7);
    exp_q.push_back(3'h0);
    put(OIBC_CMD_AXIS_MOVE, 3'h0);
    fin();
    repeat (5) @(posedge clk);
    check({2'b00, exp_q.size() == 0}, 3'h1, "queue");
    stop_test();
  end
endmodule
`default_nettype wire
